// File: rtl/tpt_j1_source.sv
// tpt_j1_source: transmit J1 path trace source for four overhead channels.
// assumes frameTick marks each outbound frame on core_clk; the serial port partner
// samples the derived overhead clock and answers on its falling edges.
`default_nettype none

// register map, as word indices (byte address is four times the index):
//   channel n = 0..3 uses the top nibble n+1 of the 16-bit index
//   index 0xN993 trace byte value, eight bits, read/write
//   index 0xN9BB control: length code in 3:2, source code in 1:0
//   index 0xND00-0xND3F trace buffer, one byte per location
//   any other index reads zero and ignores writes
// only byte lane 0 carries data; a write with that lane off is dropped,
// and the upper 24 bits of read data are always zero.
//
// bus timing: a request seen in the idle state gets waitrequest low in
// the very next cycle, for exactly one cycle. writes land at the edge
// that closes that cycle, and read data stand in it. back-to-back requests
// therefore cost two cycles each; there are no further wait states.
//
// frame path: each frameTick starts a walk over channels 0..3, one word
// per cycle while the output buffer has room. a word carries the channel
// in its top two bits and the J1 byte below. the byte is chosen when the
// word is pushed, so a register written during a stall still counts.
// a tick that arrives during the walk is dropped; frames are far apart
// compared with the four cycles the walk needs.
//
// buffer mode: each channel keeps its own message pointer, which steps
// once per frame and wraps after the last byte of the set length. if the
// length is cut below the pointer, the pointer wraps on the next frame
// rather than wandering through stale bytes beyond the message.
//
// serial port: the overhead clock is the core clock divided by sixteen,
// high for eight cycles and low for eight. it runs freely, so the partner
// may use it as a steady reference. a frame raises a pending flag; at the
// next falling edge with no byte under way, slot-valid and frame-mark go
// high for one serial period. the partner then drives the MSB at the
// falling edge that ends the slot and seven more bits after it.
// each bit is latched four core cycles after a rising edge, which leaves
// the three-stage synchroniser ample time to settle.
// the byte received in one frame is used from the next frame's push on:
// the push happens right after the tick, long before the byte arrives.
//
// limitations: no parity or framing check on the serial byte; a missed
// slot still latches whatever eight bits the line carries. trace buffer contents are not reset,
// so software must load a message before selecting buffer mode.

module tpt_j1_source
  import tpt_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  input  wire logic [17:0]        avsAddress,
  input  wire logic               avsRead,
  input  wire logic               avsWrite,
  input  wire logic [31:0]        avsWriteData,
  input  wire logic [3:0]         avsByteEnable,
  output logic [31:0]             avsReadData,
  output logic                    avsWaitRequest,
  input  wire logic               frameTick,
  input  wire logic [NUM_CH-1:0]  overheadSerialIn,
  output logic                    overheadSerialClock,
  output logic                    overheadSlotValid,
  output logic                    overheadFrameMark,
  output logic                    j1Valid,
  output logic [1:0]              j1Channel,
  output logic [7:0]              j1Data,
  input  wire logic               j1Ready
);

  typedef struct packed {
    tpt_bus_t               busSt;
    logic                   waitReq;
    logic [7:0]             rdData;
    logic [NUM_CH-1:0][3:0] ctrl;
    logic [NUM_CH-1:0][7:0] value;
    logic [NUM_CH-1:0][5:0] msgPtr;
    logic                   seqBusy;
    logic [1:0]             seqCh;
    logic [3:0]             divCnt;
    logic                   serClk;
    logic                   slotPend;
    logic                   slotOn;
    logic [3:0]             bitCnt;
    logic [NUM_CH-1:0]      sync1;
    logic [NUM_CH-1:0]      sync2;
    logic [NUM_CH-1:0]      sync3;
    logic [NUM_CH-1:0]      pinLvl;
    logic [NUM_CH-1:0][7:0] shift;
    logic [NUM_CH-1:0][7:0] extByte;
  } tpt_state_t;

  tpt_state_t          st_reg;
  tpt_state_t          st_next;
  logic [7:0]          traceMem [NUM_CH][BUF_DEPTH];
  tpt_dec_t            dec;
  logic                memWe;
  logic                pushValid;
  logic [WORD_W-1:0]   pushWord;
  logic                pushReady;
  logic [WORD_W-1:0]   outWord;

  // last buffer index for a length code
  function automatic logic [5:0] lastIdx(input logic [1:0] len);
    case (len)
      LEN_1:   lastIdx = LAST_1;
      LEN_16:  lastIdx = LAST_16;
      default: lastIdx = LAST_64;
    endcase
  endfunction

  // address index to register kind, channel and buffer offset
  function automatic tpt_dec_t decode(input logic [15:0] idx);
    logic [3:0] nib;
    nib          = idx[15:12] - CH_NIB_FIRST;
    decode.kind  = ACC_NONE;
    decode.ch    = nib[1:0];
    decode.ofs   = idx[5:0];
    if (idx[15:12] >= CH_NIB_FIRST && nib < 4'(NUM_CH)) begin
      if (idx[11:0] == IDX_VALUE) begin
        decode.kind = ACC_VALUE;
      end else if (idx[11:0] == IDX_CTRL) begin
        decode.kind = ACC_CTRL;
      end else if (idx[11:0] >= IDX_BUF_BASE && idx[11:0] <= IDX_BUF_LAST) begin
        decode.kind = ACC_BUF;
      end
    end
  endfunction

  // J1 byte for one channel according to its source select
  function automatic logic [7:0] j1Byte(input tpt_state_t s, input logic [7:0] bufByte,
                                        input logic [1:0] ch);
    case (s.ctrl[ch][CTRL_SRC_LSB +: 2])
      SRC_ZERO:     j1Byte = ZERO_BYTE;
      SRC_BUFFER:   j1Byte = bufByte;
      SRC_REGISTER: j1Byte = s.value[ch];
      default:      j1Byte = s.extByte[ch];
    endcase
  endfunction

  assign dec                 = decode(avsAddress[17:2]);
  assign avsReadData         = {24'h000000, st_reg.rdData};
  assign avsWaitRequest      = st_reg.waitReq;
  assign overheadSerialClock = st_reg.serClk;
  assign overheadSlotValid   = st_reg.slotOn;
  assign overheadFrameMark   = st_reg.slotOn;
  assign j1Channel           = outWord[WORD_W-1 -: 2];
  assign j1Data              = outWord[7:0];
  assign pushWord            = {st_reg.seqCh,
                                j1Byte(st_reg, traceMem[st_reg.seqCh][st_reg.msgPtr[st_reg.seqCh]],
                                       st_reg.seqCh)};
  assign pushValid           = st_reg.seqBusy;
  // buffer writes land at the edge where waitrequest is low, like the registers
  assign memWe               = st_reg.busSt == BUS_ANS && avsWrite && avsByteEnable[0]
                               && dec.kind == ACC_BUF;

  // next state: bus slave, serial port, frame sequencer
  always_comb begin
    st_next = st_reg;

    // bus slave: one idle cycle with waitrequest high, then one answer cycle
    case (st_reg.busSt)
      BUS_IDLE: begin
        if (avsRead || avsWrite) begin
          st_next.busSt   = BUS_ANS;
          st_next.waitReq = 1'b0;
          case (dec.kind)
            ACC_VALUE: st_next.rdData = st_reg.value[dec.ch];
            ACC_CTRL:  st_next.rdData = {4'h0, st_reg.ctrl[dec.ch]};
            ACC_BUF:   st_next.rdData = traceMem[dec.ch][dec.ofs];
            default:   st_next.rdData = 8'h00;
          endcase
        end
      end
      BUS_ANS: begin
        st_next.busSt   = BUS_IDLE;
        st_next.waitReq = 1'b1;
        if (avsWrite && avsByteEnable[0]) begin
          if (dec.kind == ACC_VALUE) begin
            st_next.value[dec.ch] = avsWriteData[7:0];
          end
          if (dec.kind == ACC_CTRL) begin
            st_next.ctrl[dec.ch] = avsWriteData[3:0];
          end
        end
      end
      default: begin
        st_next.busSt   = BUS_IDLE;
        st_next.waitReq = 1'b1;
      end
    endcase

    // overhead clock divider: high in the first half of each period
    st_next.divCnt = (st_reg.divCnt == SER_DIV_LAST) ? 4'h0 : st_reg.divCnt + 4'h1;
    st_next.serClk = st_next.divCnt < SER_HALF;

    // pin synchronisers; a level counts once stages two and three agree
    st_next.sync1 = overheadSerialIn;
    st_next.sync2 = st_reg.sync1;
    st_next.sync3 = st_reg.sync2;
    for (int i = 0; i < NUM_CH; i++) begin
      if (st_reg.sync2[i] == st_reg.sync3[i]) begin
        st_next.pinLvl[i] = st_reg.sync3[i];
      end
    end

    // slot marker: raised on a falling edge, held one serial period
    if (st_next.divCnt == SER_HALF) begin
      if (st_reg.slotOn) begin
        st_next.slotOn = 1'b0;
        st_next.bitCnt = SER_BITS;
      end else if (st_reg.slotPend && st_reg.bitCnt == 4'h0) begin
        st_next.slotOn   = 1'b1;
        st_next.slotPend = 1'b0;
      end
    end
    // a new frame wins over the clear of the pending flag
    if (frameTick) begin
      st_next.slotPend = 1'b1;
    end

    // bits are latched after each rising edge, once the synchroniser has settled
    if (st_reg.divCnt == SER_SAMPLE && st_reg.bitCnt != 4'h0) begin
      st_next.bitCnt = st_reg.bitCnt - 4'h1;
      for (int i = 0; i < NUM_CH; i++) begin
        st_next.shift[i] = {st_reg.shift[i][6:0], st_reg.pinLvl[i]};
        if (st_reg.bitCnt == 4'h1) begin
          st_next.extByte[i] = {st_reg.shift[i][6:0], st_reg.pinLvl[i]};
        end
      end
    end

    // frame sequencer: one J1 word per channel per frame into the buffer
    if (st_reg.seqBusy && pushReady) begin
      st_next.seqCh = st_reg.seqCh + 2'h1;
      if (st_reg.seqCh == 2'(NUM_CH - 1)) begin
        st_next.seqBusy = 1'b0;
      end
      if (st_reg.ctrl[st_reg.seqCh][CTRL_SRC_LSB +: 2] == SRC_BUFFER) begin
        // a shortened length wraps at once rather than running off the end
        if (st_reg.msgPtr[st_reg.seqCh] >= lastIdx(st_reg.ctrl[st_reg.seqCh][CTRL_LEN_LSB +: 2]))
        begin
          st_next.msgPtr[st_reg.seqCh] = 6'h00;
        end else begin
          st_next.msgPtr[st_reg.seqCh] = st_reg.msgPtr[st_reg.seqCh] + 6'h01;
        end
      end
    end
    // ticks during the four-cycle walk are dropped; frames are far apart
    if (frameTick && !st_reg.seqBusy) begin
      st_next.seqBusy = 1'b1;
      st_next.seqCh   = 2'h0;
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_reg         <= '0;
      st_reg.busSt   <= BUS_IDLE;
      st_reg.waitReq <= 1'b1;
      // first count after reset is zero, so the first high phase is full length
      st_reg.divCnt  <= SER_DIV_LAST;
      st_reg.ctrl    <= {NUM_CH{CTRL_RESET}};
      st_reg.value   <= {NUM_CH{VALUE_RESET}};
    end else begin
      st_reg <= st_next;
    end
  end

  // trace message buffers, one window per channel; contents survive reset
  always_ff @(posedge core_clk) begin
    if (memWe) begin
      traceMem[dec.ch][dec.ofs] <= avsWriteData[7:0];
    end
  end

  // outbound words wait here so a stall downstream loses nothing
  tpt_pair_buffer u_outBuf (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .inValid  (pushValid),
    .inData   (pushWord),
    .inReady  (pushReady),
    .outValid (j1Valid),
    .outData  (outWord),
    .outReady (j1Ready)
  );

endmodule

`default_nettype wire

// File: rtl/tpt_pkg.sv
// tpt_pkg: constants and types for the transmit path trace (J1) source.
// assumes a 100 MHz core clock and a 32-bit Avalon-MM slave with word addressing by index.
`default_nettype none

package tpt_pkg;

  // channel count and trace buffer depth
  localparam int          NUM_CH        = 4;
  localparam int          BUF_DEPTH     = 64;

  // register indices; byte address is four times the index
  localparam logic [3:0]  CH_NIB_FIRST  = 4'h1;    // channel 0 lives at 0x1xxx
  localparam logic [11:0] IDX_VALUE     = 12'h993;
  localparam logic [11:0] IDX_CTRL      = 12'h9bb;
  localparam logic [11:0] IDX_BUF_BASE  = 12'hd00;
  localparam logic [11:0] IDX_BUF_LAST  = 12'hd3f;

  // control register fields
  localparam int          CTRL_SRC_LSB  = 0;
  localparam int          CTRL_LEN_LSB  = 2;
  localparam logic [3:0]  CTRL_RESET    = 4'h0;
  localparam logic [7:0]  VALUE_RESET   = 8'h00;
  localparam logic [7:0]  ZERO_BYTE     = 8'h00;

  // source select codes
  localparam logic [1:0]  SRC_ZERO      = 2'h0;
  localparam logic [1:0]  SRC_BUFFER    = 2'h1;
  localparam logic [1:0]  SRC_REGISTER  = 2'h2;
  localparam logic [1:0]  SRC_SERIAL    = 2'h3;

  // message length codes and last buffer index for each
  localparam logic [1:0]  LEN_1         = 2'h0;
  localparam logic [1:0]  LEN_16        = 2'h1;
  localparam logic [5:0]  LAST_1        = 6'h00;
  localparam logic [5:0]  LAST_16       = 6'h0f;
  localparam logic [5:0]  LAST_64       = 6'h3f;

  // serial overhead clock, derived from the core clock
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          SER_PERIOD_NS = 160;
  localparam logic [3:0]  SER_DIV_LAST  = 4'(SER_PERIOD_NS / CLK_PERIOD_NS - 1);
  localparam logic [3:0]  SER_HALF      = 4'(SER_PERIOD_NS / CLK_PERIOD_NS / 2);
  localparam logic [3:0]  SER_SAMPLE    = 4'h4;    // core cycles after the rising edge
  localparam logic [3:0]  SER_BITS      = 4'h8;

  // outbound word: channel then J1 byte
  localparam int          WORD_W        = 10;

  // bus slave states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ANS  = 2'b10
  } tpt_bus_t;

  // decoded register access
  typedef enum logic [3:0] {
    ACC_NONE  = 4'b0001,
    ACC_VALUE = 4'b0010,
    ACC_CTRL  = 4'b0100,
    ACC_BUF   = 4'b1000
  } tpt_acc_t;

  typedef struct packed {
    tpt_acc_t   kind;
    logic [1:0] ch;
    logic [5:0] ofs;
  } tpt_dec_t;

endpackage

`default_nettype wire

// File: rtl/tpt_pair_buffer.sv
// tpt_pair_buffer: two-entry valid/ready buffer for outbound J1 words.
// assumes both sides on core_clk; outputs come from flip-flops.
`default_nettype none

module tpt_pair_buffer
  import tpt_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic              inValid,
  input  wire logic [WORD_W-1:0] inData,
  output logic                   inReady,
  output logic                   outValid,
  output logic [WORD_W-1:0]      outData,
  input  wire logic              outReady
);

  typedef struct packed {
    logic              v0;
    logic              v1;
    logic [WORD_W-1:0] d0;
    logic [WORD_W-1:0] d1;
  } tpt_pbuf_t;

  tpt_pbuf_t st_reg;
  tpt_pbuf_t st_next;
  logic      push;
  logic      pop;

  assign inReady  = !st_reg.v1;
  assign outValid = st_reg.v0;
  assign outData  = st_reg.d0;
  assign push     = inValid && !st_reg.v1;
  assign pop      = st_reg.v0 && outReady;

  // pop shifts the tail forward before a push fills the first free slot
  always_comb begin
    st_next = st_reg;
    if (pop) begin
      st_next.d0 = st_reg.d1;
      st_next.v0 = st_reg.v1;
      st_next.v1 = 1'b0;
    end
    if (push) begin
      if (!st_next.v0) begin
        st_next.d0 = inData;
        st_next.v0 = 1'b1;
      end else begin
        st_next.d1 = inData;
        st_next.v1 = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

`default_nettype wire

// File: dv/tpt_j1_source_props.sv
// tpt_j1_source_props: concurrent checks on the J1 source ports.
// assumes one core_clk domain with sys_rst synchronous, active high.
`default_nettype none

module tpt_j1_source_props
  import tpt_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic [17:0] avsAddress,
  input wire logic        avsRead,
  input wire logic        avsWrite,
  input wire logic [31:0] avsReadData,
  input wire logic        avsWaitRequest,
  input wire logic        overheadSerialClock,
  input wire logic        overheadSlotValid,
  input wire logic        overheadFrameMark,
  input wire logic        j1Valid,
  input wire logic [1:0]  j1Channel,
  input wire logic [7:0]  j1Data,
  input wire logic        j1Ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  logic [1:0] nextCh_reg;
  logic       rdAns;

  // channel expected on the next taken word; a lost or repeated word breaks the order
  always_ff @(posedge core_clk) begin
    if (sys_rst) nextCh_reg <= 2'h0;
    else if (j1Valid && j1Ready) nextCh_reg <= j1Channel + 2'h1;
  end
  assign rdAns = avsRead && !avsWaitRequest;

  property p_ans; $rose(avsRead) || $rose(avsWrite) |=> !avsWaitRequest; endproperty
  a_ans: assert property (p_ans) else $error("bus request not answered next cycle");
  property p_one; !avsWaitRequest |=> avsWaitRequest; endproperty
  a_one: assert property (p_one) else $error("answer lasted more than one cycle");
  property p_upper; rdAns |-> avsReadData[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("read data above the byte not zero");
  property p_ctrl; rdAns && avsAddress[13:2] == IDX_CTRL |-> avsReadData[7:4] == 4'h0; endproperty
  a_ctrl: assert property (p_ctrl) else $error("control upper bits not zero");
  property p_unmap; rdAns && avsAddress[17:14] == 4'h0 |-> avsReadData == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_hold; j1Valid && !j1Ready |=> j1Valid && $stable(j1Data) && $stable(j1Channel);
  endproperty
  a_hold: assert property (p_hold) else $error("stalled word changed");
  property p_order; j1Valid && j1Ready |-> j1Channel == nextCh_reg; endproperty
  a_order: assert property (p_order) else $error("word out of channel order");
  property p_mark; overheadSlotValid == overheadFrameMark; endproperty
  a_mark: assert property (p_mark) else $error("slot and frame mark differ");
  property p_slot;
    $rose(overheadSlotValid) |-> overheadSlotValid[*8] ##1 overheadSlotValid[*8]
      ##1 !overheadSlotValid;
  endproperty
  a_slot: assert property (p_slot) else $error("slot not one serial period");
  property p_sclk; $rose(overheadSerialClock) |-> overheadSerialClock[*8] ##1 !overheadSerialClock;
  endproperty
  a_sclk: assert property (p_sclk) else $error("serial clock high phase wrong");

  // main scenarios reached
  c_take3: cover property (j1Valid && j1Ready && j1Channel == 2'h3);
  c_stall: cover property (j1Valid && !j1Ready);
  c_slot: cover property ($rose(overheadSlotValid));
  c_read: cover property (rdAns);
endmodule

bind tpt_j1_source tpt_j1_source_props u_props (
  .core_clk(core_clk), .sys_rst(sys_rst), .avsAddress(avsAddress), .avsRead(avsRead),
  .avsWrite(avsWrite), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
  .overheadSerialClock(overheadSerialClock), .overheadSlotValid(overheadSlotValid),
  .overheadFrameMark(overheadFrameMark), .j1Valid(j1Valid), .j1Channel(j1Channel),
  .j1Data(j1Data), .j1Ready(j1Ready));

`default_nettype wire

// File: dv/tpt_serial_partner.sv
// tpt_serial_partner: external circuit feeding J1 bytes on the serial overhead port.
// assumes the device drives the serial clock, slot-valid and frame-mark outputs.
`default_nettype none

module tpt_serial_partner (
  input  wire logic            overheadSerialClock,
  input  wire logic            overheadSlotValid,
  input  wire logic            overheadFrameMark,
  input  wire logic [3:0][7:0] txBytes,
  output var  logic [3:0]      serialOut
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0][7:0] shift;
  int              left = 0;

  initial serialOut = 4'h0;
  // sample on rising serial edges, drive on falling ones
  always @(overheadSerialClock) begin
    if (overheadSerialClock === 1'b1) begin
      if (overheadSlotValid && overheadFrameMark && left == 0) begin
        shift = txBytes;
        left = 8;
      end
    end else if (left > 0) begin
      // msb first, then seven more
      for (int c = 0; c < 4; c++) serialOut[c] <= shift[c][7];
      for (int c = 0; c < 4; c++) shift[c] = shift[c] << 1;
      left = left - 1;
    end else begin
      serialOut <= ~serialOut; // back to watching; line never holds the last bit
    end
  end
endmodule

`default_nettype wire

// File: dv/tpt_j1_source_tb.sv
// tpt_j1_source_tb: self-checking bench for the transmit J1 source.
// assumes the props checker binds itself and the serial partner is compiled.
`default_nettype none

module tpt_j1_source_tb
  import tpt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] d; logic [1:0] ch; bit care;} tpt_word_t;
  logic            core_clk = 1'b0, sys_rst = 1'b1, avsRead = 1'b0, avsWrite = 1'b0;
  logic            frameTick = 1'b0, j1Ready = 1'b1;
  logic [17:0]     avsAddress = 18'h0;
  logic [31:0]     avsWriteData = 32'h0, avsReadData;
  logic [3:0]      avsByteEnable = 4'h0, overheadSerialIn;
  logic            avsWaitRequest, overheadSerialClock, overheadSlotValid, overheadFrameMark;
  logic            j1Valid;
  logic [1:0]      j1Channel;
  logic [7:0]      j1Data;
  logic [3:0][7:0] serB = 32'h0;
  logic [7:0]      bufm [4][64];
  logic [7:0]      valm [4], prevSer [4], cfg [4];
  integer          seed = 32'h751c;
  int              fail_count = 0, n_tests = 0;
  tpt_word_t       wq [$], w;
  logic [31:0]     rq [$];

  initial forever #5 core_clk = ~core_clk;

  tpt_j1_source DUT (.core_clk(core_clk), .sys_rst(sys_rst), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(avsByteEnable), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .frameTick(frameTick), .overheadSerialIn(overheadSerialIn),
    .overheadSerialClock(overheadSerialClock), .overheadSlotValid(overheadSlotValid),
    .overheadFrameMark(overheadFrameMark), .j1Valid(j1Valid), .j1Channel(j1Channel),
    .j1Data(j1Data), .j1Ready(j1Ready));
  tpt_serial_partner u_far (.overheadSerialClock(overheadSerialClock),
    .overheadSlotValid(overheadSlotValid), .overheadFrameMark(overheadFrameMark),
    .txBytes(serB), .serialOut(overheadSerialIn));

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // one bus transfer, held until waitrequest is seen low
  task automatic bus(logic [17:0] a, logic wr, logic [7:0] d, logic [3:0] be);
    int n;
    n = 0;
    avsAddress <= a;
    avsRead <= !wr;
    avsWrite <= wr;
    avsWriteData <= {24'h0, d};
    avsByteEnable <= be;
    do begin
      @(posedge core_clk);
      n++;
    end while (avsWaitRequest !== 1'b0 && n < 64);
    if (n >= 64) chk("bus answer", 32'h1, 32'h0);
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    @(posedge core_clk);
  endtask

  function automatic logic [17:0] ad(int c, logic [11:0] i);
    return {4'(c + 1), i, 2'b00};
  endfunction

  task automatic wr(int c, logic [11:0] i, logic [7:0] d);
    bus(ad(c, i), 1'b1, d, 4'h1);
  endtask

  task automatic rd(logic [17:0] a, logic [7:0] e);
    rq.push_back({24'h0, e});
    bus(a, 1'b0, 8'h0, 4'h1);
  endtask

  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
  endtask

  // program all four control registers from cfg and read them back
  task automatic setup();
    for (int c = 0; c < 4; c++) begin
      wr(c, IDX_CTRL, cfg[c]);
      rd(ad(c, IDX_CTRL), {4'h0, cfg[c][3:0]});
    end
  endtask

  // frames since reset; the note for each word is made before the frame starts
  task automatic frames(int nf);
    int L;
    for (int k = 0; k < nf; k++) begin
      valm[2] = 8'($random(seed));
      wr(2, IDX_VALUE, valm[2]);
      serB = $random(seed);
      for (int c = 0; c < 4; c++) begin
        L = cfg[c][3:2] == 2'h0 ? 1 : cfg[c][3:2] == 2'h1 ? 16 : 64;
        w.ch = 2'(c);
        w.care = cfg[c][1:0] != SRC_SERIAL || k > 0;
        case (cfg[c][1:0])
          SRC_ZERO: w.d = 8'h00;
          SRC_BUFFER: w.d = bufm[c][k % L];
          SRC_REGISTER: w.d = valm[c];
          default: w.d = prevSer[c]; // serial byte lands one frame late
        endcase
        wq.push_back(w);
        prevSer[c] = serB[c];
      end
      frameTick <= 1'b1;
      @(posedge core_clk);
      frameTick <= 1'b0;
      repeat (220) @(posedge core_clk);
    end
  endtask

  // receiver stalls about one cycle in four
  always @(posedge core_clk) j1Ready <= ($random(seed) & 3) != 0;

  // watcher: each answer or taken word is compared with the oldest note
  always @(posedge core_clk) begin
    if (avsRead === 1'b1 && avsWaitRequest === 1'b0) chk("readdata", avsReadData, rq.pop_front());
    if (j1Valid === 1'b1 && j1Ready === 1'b1) begin
      w = wq.pop_front();
      chk("channel", j1Channel, w.ch);
      if (w.care) chk("j1 byte", j1Data, w.d);
    end
  end

  initial begin
    do_reset();
    for (int c = 0; c < 4; c++) begin
      rd(ad(c, IDX_CTRL), 8'h00);
      rd(ad(c, IDX_VALUE), 8'h00);
      for (int i = 0; i < 64; i++) begin
        bufm[c][i] = 8'($random(seed));
        wr(c, IDX_BUF_BASE + 12'(i), bufm[c][i]); // first byte lowest
      end
      rd(ad(c, IDX_BUF_BASE), bufm[c][0]);
      rd(ad(c, IDX_BUF_LAST), bufm[c][63]);
    end
    rd({4'h0, IDX_VALUE, 2'b00}, 8'h00);
    bus(ad(2, IDX_VALUE), 1'b1, 8'h5a, 4'h0);
    rd(ad(2, IDX_VALUE), 8'h00); // lane off, write dropped
    $display("test registers done");
    cfg = '{8'hf0, 8'h05, 8'h02, 8'h03};
    setup();
    frames(18);
    $display("test mixed sources done");
    do_reset();
    cfg = '{8'h01, 8'h09, 8'h0d, 8'hf0};
    setup();
    frames(66);
    repeat (20) @(posedge core_clk);
    chk("words left", 32'(wq.size()), 32'h0);
    $display("test buffer lengths done");
    close_out();
  end

  // watchdog well beyond the expected run of about 200 us
  initial begin
    #1ms;
    fail_count++;
    close_out();
  end
endmodule

`default_nettype wire
